/* logic/flash_program_protect_ctrl.sv */
// Summary of operation
// - program address and byte count are multiples of four
// - controller signals completion of each word program
// - failed program is flagged separately from completion
// - each 2 kB block holds one of three protection states
// - full-access block allows read, fetch, erase and program
// - read-only block allows read and fetch, refuses erase and program
// - fetch-only block denies processor and debugger data reads
// - protection may only become stricter
// - fetch-only is final; loosening requests are rejected, state kept
// - uncommitted protection lasts until reset, then committed state returns
// - protection violations raise the invalid-access interrupt source
// - protection commit stores current protection in non-volatile state
// - two user words readable and writable by software
// - user commit makes the two user words permanent; here they survive resetn, but power-on reset (por_n) returns them to all ones
// - programming only clears bits; erase sets them
// - erase clears a 1 kB page to all ones
// - program or erase completion raises an interrupt source
// - per-source enables; raw and masked status readable; masked drive irq
//
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
`include "flash_prot_params.svh"

module flash_program_protect_ctrl (
  input  wire logic                    mclk,
  input  wire logic                    resetn,
  input  wire logic                    por_n,
  input  wire logic [5:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic [31:0]                  avs_readdata,
  output logic                         avs_waitrequest,
  input  wire flash_prot_pkg::rd_req_s fl_req,
  output flash_prot_pkg::rd_rsp_s      fl_rsp,
  output logic                         irq
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [31:0]             mem [`FP_WORDS];

  flash_prot_pkg::fsm_e    st_r;
  flash_prot_pkg::fsm_e    st_nxt;
  flash_prot_pkg::op_e     op_r;
  flash_prot_pkg::op_e     op_nxt;
  logic [7:0]              cnt_r;
  logic [7:0]              cnt_nxt;
  logic [31:0]             addr_r;
  logic [31:0]             addr_nxt;
  logic [31:0]             data_r;
  logic [31:0]             data_nxt;
  logic [2:0]              stat_r;
  logic [2:0]              stat_nxt;
  logic [2:0]              mask_r;
  logic [2:0]              mask_nxt;
  logic [7:0]              prot_r;
  logic [7:0]              prot_nxt;
  logic [31:0]             user0_r;
  logic [31:0]             user0_nxt;
  logic [31:0]             user1_r;
  logic [31:0]             user1_nxt;
  logic                    load_r;
  logic                    load_nxt;
  logic [7:0]              nv_prot_r;
  logic [7:0]              nv_prot_nxt;
  logic [31:0]             nv_user0_r;
  logic [31:0]             nv_user0_nxt;
  logic [31:0]             nv_user1_r;
  logic [31:0]             nv_user1_nxt;
  logic [31:0]             rdata_r;
  logic [31:0]             rdata_nxt;
  logic                    rack_r;
  logic                    rack_nxt;
  flash_prot_pkg::rd_rsp_s rsp_r;
  flash_prot_pkg::rd_rsp_s rsp_nxt;

  logic                    busy;
  logic                    wr_hit;
  logic [31:0]             wmask;
  logic [31:0]             wdm;
  logic [7:0]              prot_upd;
  logic [7:0]              prot_eff;
  logic [1:0]              tgt_lvl;
  logic [1:0]              rd_lvl;
  logic                    bad_addr;
  logic                    rd_deny;
  logic                    prog_fin;
  logic                    mem_we;
  logic [10:0]             mem_wa;
  logic [31:0]             mem_wd;
  logic [2:0]              set;
  logic [2:0]              clr;

  ////////////////////////////////////////////////////////////////////////////
  // bus front end

  assign busy   = (st_r != flash_prot_pkg::st_idle) | load_r;
  assign wr_hit = avs_write & ~avs_waitrequest;

  // a command write waits while an operation runs; reads take one wait cycle
  assign avs_waitrequest = (avs_read & ~rack_r) |
                           (avs_write & busy & (avs_address == `FP_OFS_CMD));
  assign avs_readdata    = rdata_r;
  assign fl_rsp          = rsp_r;
  assign irq             = |(stat_r & mask_r);

  for (genvar bi = 0; bi < 4; bi++) begin : g_be
    assign wmask[8*bi +: 8] = {8{avs_byteenable[bi]}};
  end
  assign wdm = avs_writedata & wmask;

  ////////////////////////////////////////////////////////////////////////////
  // per-block protection

  // during the load cycle after reset the committed image is in force
  assign prot_eff = load_r ? nv_prot_r : prot_r;

  for (genvar gi = 0; gi < `FP_BLOCKS; gi++) begin : g_blk
    logic [1:0] cur;
    logic [1:0] req;
    assign cur = prot_r[2*gi +: 2];
    assign req = avs_writedata[2*gi +: 2];
    // only equal or stricter levels are taken; fetch-only never changes
    assign prot_upd[2*gi +: 2] =
      (req >= cur && req != 2'h3) ? req : cur;

    a_prot_no_loosen: assert property (
      @(posedge mclk) disable iff (!resetn)
      !$past(load_r) |-> prot_r[2*gi +: 2] >= $past(prot_r[2*gi +: 2]))
      else $error("protection level loosened");
    a_fetch_final: assert property (
      @(posedge mclk) disable iff (!resetn)
      (!load_r && prot_r[2*gi +: 2] == flash_prot_pkg::prot_fetch_only)
      |=> prot_r[2*gi +: 2] == flash_prot_pkg::prot_fetch_only)
      else $error("fetch-only block changed");
  end

  assign tgt_lvl  = prot_r[{addr_r[12:11], 1'b0} +: 2];
  assign rd_lvl   = prot_eff[{fl_req.addr[12:11], 1'b0} +: 2];
  assign rd_deny  = fl_req.req & ~fl_req.fetch &
                    (rd_lvl == flash_prot_pkg::prot_fetch_only);
  assign prog_fin = (st_r == flash_prot_pkg::st_run) &
                    (op_r == flash_prot_pkg::op_prog) & (cnt_r == 8'h00);

  ////////////////////////////////////////////////////////////////////////////
  // control next state

  always_comb begin
    st_nxt       = st_r;
    op_nxt       = op_r;
    cnt_nxt      = cnt_r;
    addr_nxt     = addr_r;
    data_nxt     = data_r;
    mask_nxt     = mask_r;
    prot_nxt     = prot_r;
    user0_nxt    = user0_r;
    user1_nxt    = user1_r;
    load_nxt     = 1'b0;
    nv_prot_nxt  = nv_prot_r;
    nv_user0_nxt = nv_user0_r;
    nv_user1_nxt = nv_user1_r;
    mem_we       = 1'b0;
    mem_wa       = addr_r[12:2];
    mem_wd       = mem[addr_r[12:2]] & data_r;
    set          = 3'h0;
    clr          = 3'h0;
    bad_addr     = addr_r[1:0] != 2'h0 ||
                   addr_r[31:`FP_ADDR_W] != 19'h0;

    if (load_r) begin
      prot_nxt  = nv_prot_r;
      user0_nxt = nv_user0_r;
      user1_nxt = nv_user1_r;
    end

    if (wr_hit) begin
      unique case (avs_address)
        `FP_OFS_ADDR:  addr_nxt  = (addr_r & ~wmask) | wdm;
        `FP_OFS_DATA:  data_nxt  = (data_r & ~wmask) | wdm;
        `FP_OFS_MASK:  mask_nxt  = wmask[0] ? wdm[2:0] : mask_r;
        `FP_OFS_STAT:  clr       = wdm[2:0];
        `FP_OFS_USER0: user0_nxt = (user0_r & ~wmask) | wdm;
        `FP_OFS_USER1: user1_nxt = (user1_r & ~wmask) | wdm;
        `FP_OFS_PROT: begin
          if (avs_byteenable[0]) begin
            prot_nxt = prot_upd;
          end
        end
        `FP_OFS_CMD: begin
          if (wdm[`FP_CMD_PROG]) begin
            if (bad_addr) begin
              set[`FP_ST_PERR] = 1'b1;
            end else if (tgt_lvl != flash_prot_pkg::prot_full_access) begin
              set[`FP_ST_ACC] = 1'b1;
            end else begin
              st_nxt  = flash_prot_pkg::st_run;
              op_nxt  = flash_prot_pkg::op_prog;
              cnt_nxt = 8'(`FP_PROG_CYC - 1);
            end
          end else if (wdm[`FP_CMD_ERASE]) begin
            if (bad_addr || addr_r[9:0] != 10'h0) begin
              set[`FP_ST_PERR] = 1'b1;
            end else if (tgt_lvl != flash_prot_pkg::prot_full_access) begin
              set[`FP_ST_ACC] = 1'b1;
            end else begin
              st_nxt  = flash_prot_pkg::st_run;
              op_nxt  = flash_prot_pkg::op_erase;
              cnt_nxt = `FP_PAGE_LAST;
            end
          end else if (wdm[`FP_CMD_PSAVE]) begin
            st_nxt  = flash_prot_pkg::st_run;
            op_nxt  = flash_prot_pkg::op_psave;
            cnt_nxt = 8'(`FP_PROG_CYC - 1);
          end else if (wdm[`FP_CMD_USAVE]) begin
            st_nxt  = flash_prot_pkg::st_run;
            op_nxt  = flash_prot_pkg::op_usave;
            cnt_nxt = 8'(`FP_PROG_CYC - 1);
          end
        end
        default: ;
      endcase
    end

    if (st_r == flash_prot_pkg::st_run) begin
      cnt_nxt = cnt_r - 8'h01;
      if (op_r == flash_prot_pkg::op_erase) begin
        // one word of the page per cycle
        mem_we = 1'b1;
        mem_wa = {addr_r[12:10], cnt_r};
        mem_wd = `FP_NV_USER_RST;
      end
      if (cnt_r == 8'h00) begin
        st_nxt = flash_prot_pkg::st_idle;
        set[`FP_ST_DONE] = 1'b1;
        unique case (op_r)
          flash_prot_pkg::op_prog:  mem_we = 1'b1;
          flash_prot_pkg::op_erase: ;
          flash_prot_pkg::op_psave: nv_prot_nxt = prot_r;
          flash_prot_pkg::op_usave: begin
            nv_user0_nxt = user0_r;
            nv_user1_nxt = user1_r;
          end
        endcase
      end
    end

    if (rd_deny) begin
      set[`FP_ST_ACC] = 1'b1;
    end
    // an event in the same cycle as its clear wins
    stat_nxt = (stat_r & ~clr) | set;
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus and fetch answers

  always_comb begin
    rack_nxt  = avs_read & ~rack_r;
    rdata_nxt = rdata_r;
    if (avs_read & ~rack_r) begin
      unique case (avs_address)
        `FP_OFS_ADDR:  rdata_nxt = addr_r;
        `FP_OFS_DATA:  rdata_nxt = data_r;
        `FP_OFS_CMD:   rdata_nxt = {31'h0, busy};
        `FP_OFS_STAT:  rdata_nxt = {29'h0, stat_r};
        `FP_OFS_MASK:  rdata_nxt = {29'h0, mask_r};
        `FP_OFS_MSTAT: rdata_nxt = {29'h0, stat_r & mask_r};
        `FP_OFS_PROT:  rdata_nxt = {24'h0, prot_r};
        `FP_OFS_USER0: rdata_nxt = user0_r;
        `FP_OFS_USER1: rdata_nxt = user1_r;
        default:       rdata_nxt = 32'h0;
      endcase
    end
    rsp_nxt.valid  = fl_req.req;
    rsp_nxt.denied = rd_deny;
    rsp_nxt.data   = rd_deny ? 32'h0 : mem[fl_req.addr[12:2]];
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_r    <= flash_prot_pkg::st_idle;
      op_r    <= flash_prot_pkg::op_prog;
      cnt_r   <= 8'h00;
      addr_r  <= 32'h0;
      data_r  <= 32'h0;
      stat_r  <= 3'h0;
      mask_r  <= `FP_MASK_RST;
      prot_r  <= `FP_PROT_LOAD_RST;
      user0_r <= `FP_NV_USER_RST;
      user1_r <= `FP_NV_USER_RST;
      load_r  <= 1'b1;
      rdata_r <= 32'h0;
      rack_r  <= 1'b0;
      rsp_r   <= '0;
    end else begin
      st_r    <= st_nxt;
      op_r    <= op_nxt;
      cnt_r   <= cnt_nxt;
      addr_r  <= addr_nxt;
      data_r  <= data_nxt;
      stat_r  <= stat_nxt;
      mask_r  <= mask_nxt;
      prot_r  <= prot_nxt;
      user0_r <= user0_nxt;
      user1_r <= user1_nxt;
      load_r  <= load_nxt;
      rdata_r <= rdata_nxt;
      rack_r  <= rack_nxt;
      rsp_r   <= rsp_nxt;
    end
  end

  // committed settings survive chip reset; only power-on clears them
  always_ff @(posedge mclk or negedge por_n) begin
    if (!por_n) begin
      nv_prot_r  <= `FP_NV_PROT_RST;
      nv_user0_r <= `FP_NV_USER_RST;
      nv_user1_r <= `FP_NV_USER_RST;
    end else begin
      nv_prot_r  <= nv_prot_nxt;
      nv_user0_r <= nv_user0_nxt;
      nv_user1_r <= nv_user1_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_xo_deny: assert property (
    @(posedge mclk) disable iff (!resetn)
    rd_deny |=> fl_rsp.valid && fl_rsp.denied && fl_rsp.data == 32'h0
            && stat_r[`FP_ST_ACC])
    else $error("data read of fetch-only block not denied");

  a_fetch_allowed: assert property (
    @(posedge mclk) disable iff (!resetn)
    fl_req.req && fl_req.fetch |=> fl_rsp.valid && !fl_rsp.denied)
    else $error("instruction fetch denied");

  a_prog_refused: assert property (
    @(posedge mclk) disable iff (!resetn)
    wr_hit && avs_address == `FP_OFS_CMD && wdm[`FP_CMD_PROG] && !bad_addr
    && tgt_lvl != flash_prot_pkg::prot_full_access
    |=> st_r == flash_prot_pkg::st_idle && stat_r[`FP_ST_ACC])
    else $error("program of protected block not refused");

  a_misalign_err: assert property (
    @(posedge mclk) disable iff (!resetn)
    wr_hit && avs_address == `FP_OFS_CMD && wdm[`FP_CMD_PROG] && bad_addr
    |=> stat_r[`FP_ST_PERR] && st_r == flash_prot_pkg::st_idle)
    else $error("misaligned program not flagged");

  a_prog_done: assert property (
    @(posedge mclk) disable iff (!resetn)
    $rose(st_r == flash_prot_pkg::st_run) && op_r == flash_prot_pkg::op_prog
    |-> ##99 prog_fin ##1 stat_r[`FP_ST_DONE] && !busy)
    else $error("program did not complete on time");

  a_prog_and: assert property (
    @(posedge mclk) disable iff (!resetn)
    prog_fin |=> mem[$past(addr_r[12:2])] ==
                 ($past(mem[addr_r[12:2]]) & $past(data_r)))
    else $error("program set a bit");

  // checked as the load cycle ends, not at the release edge itself
  a_reset_load: assert property (
    @(posedge mclk) disable iff (!resetn)
    $fell(load_r) |-> prot_r == $past(nv_prot_r)
    && user0_r == $past(nv_user0_r) && user1_r == $past(nv_user1_r))
    else $error("committed settings not restored");

  a_prot_commit: assert property (
    @(posedge mclk) disable iff (!resetn)
    st_r == flash_prot_pkg::st_run && op_r == flash_prot_pkg::op_psave
    && cnt_r == 8'h00 |=> nv_prot_r == $past(prot_r))
    else $error("protection commit lost");

  a_user_commit: assert property (
    @(posedge mclk) disable iff (!resetn)
    st_r == flash_prot_pkg::st_run && op_r == flash_prot_pkg::op_usave
    && cnt_r == 8'h00
    |=> nv_user0_r == $past(user0_r) && nv_user1_r == $past(user1_r))
    else $error("user commit lost");

  a_irq_gate: assert property (
    @(posedge mclk) disable iff (!resetn)
    $rose(stat_r[`FP_ST_DONE]) && !mask_r[`FP_ST_DONE] && !stat_r[1]
    && !stat_r[2] |-> !irq)
    else $error("masked source reached irq");

endmodule

/* logic/flash_prot_params.svh */
`ifndef FLASH_PROT_PARAMS_SVH
`define FLASH_PROT_PARAMS_SVH

// register byte offsets
`define FP_OFS_ADDR   6'h00
`define FP_OFS_DATA   6'h04
`define FP_OFS_CMD    6'h08
`define FP_OFS_STAT   6'h0c
`define FP_OFS_MASK   6'h10
`define FP_OFS_MSTAT  6'h14
`define FP_OFS_PROT   6'h18
`define FP_OFS_USER0  6'h1c
`define FP_OFS_USER1  6'h20

// command bits (write); busy bit (read)
`define FP_CMD_PROG   0
`define FP_CMD_ERASE  1
`define FP_CMD_PSAVE  2
`define FP_CMD_USAVE  3
`define FP_CMD_BUSY   0

// status bits
`define FP_ST_DONE    0
`define FP_ST_ACC     1
`define FP_ST_PERR    2

// geometry: 8 kB array, 2 kB protection blocks, 1 kB erase pages
`define FP_ADDR_W     13
`define FP_WORDS      2048
`define FP_BLOCKS     4
`define FP_PAGE_LAST  8'hff

// reset values
`define FP_NV_PROT_RST   8'h00
`define FP_NV_USER_RST   32'hffffffff
`define FP_PROT_LOAD_RST 8'haa
`define FP_MASK_RST      3'h0

// timing
`define FP_CLK_NS        10
`define FP_PROG_TIME_NS  1000
`define FP_PROG_CYC ((`FP_PROG_TIME_NS + `FP_CLK_NS - 1) / `FP_CLK_NS)

`endif

/* logic/flash_prot_pkg.sv */
package flash_prot_pkg;

  typedef enum logic [1:0] {
    prot_full_access = 2'h0,
    prot_read_only   = 2'h1,
    prot_fetch_only  = 2'h2
  } prot_e;

  typedef enum logic [1:0] {
    st_idle = 2'h1,
    st_run  = 2'h2
  } fsm_e;

  typedef enum logic [3:0] {
    op_prog  = 4'h1,
    op_erase = 4'h2,
    op_psave = 4'h4,
    op_usave = 4'h8
  } op_e;

  typedef struct packed {
    logic        req;
    logic        fetch;
    logic        dbg;
    logic [12:0] addr;
  } rd_req_s;

  typedef struct packed {
    logic        valid;
    logic        denied;
    logic [31:0] data;
  } rd_rsp_s;

endpackage

/* verif/fetch_requester.sv */
`timescale 1ns/10ps

module fetch_requester (
  input  wire logic                    mclk,
  input  wire logic                    resetn,
  input  wire logic                    go,
  input  wire logic                    fetch,
  input  wire logic                    dbg,
  input  wire logic [12:0]             addr,
  output flash_prot_pkg::rd_req_s      fl_req,
  input  wire flash_prot_pkg::rd_rsp_s fl_rsp,
  output flash_prot_pkg::rd_rsp_s      got
);
  ////////////////////////////////////////////////////////////////////////////
  // one request per go pulse; idle qualifiers toggle so stale use shows up
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fl_req <= '0;
      got    <= '0;
    end else begin
      fl_req.req   <= go;
      fl_req.fetch <= go ? fetch : ~fl_req.fetch;
      fl_req.dbg   <= go ? dbg : ~fl_req.dbg;
      fl_req.addr  <= go ? {addr[12:2], 2'h0} : ~fl_req.addr;
      got          <= fl_rsp;
    end
  end
endmodule

/* verif/test_flash_program_protect_ctrl.sv */
`timescale 1ns/10ps
`include "flash_prot_params.svh"

module test_flash_program_protect_ctrl;
  logic                    mclk = 1'b0;
  logic                    resetn = 1'b0;
  logic                    por_n = 1'b0;
  logic [5:0]              avs_address = 6'h00;
  logic                    avs_read = 1'b0;
  logic                    avs_write = 1'b0;
  logic [31:0]             avs_writedata = 32'h0;
  logic [3:0]              avs_byteenable = 4'hf;
  logic [31:0]             avs_readdata;
  logic                    avs_waitrequest;
  flash_prot_pkg::rd_req_s fl_req;
  flash_prot_pkg::rd_rsp_s fl_rsp;
  flash_prot_pkg::rd_rsp_s got;
  logic                    irq;
  logic                    go = 1'b0;
  logic                    fetch = 1'b0;
  logic                    dbg = 1'b0;
  logic [12:0]             faddr = 13'h0;
  logic [31:0]             seed = 32'h27;
  logic [31:0]             q;
  logic [31:0]             w0;
  logic [31:0]             w1;
  logic [7:0]              pe;
  int                      errors = 0;
  int                      cmp_count = 0;

  flash_program_protect_ctrl flash_program_protect_ctrl_i (
    .mclk(mclk), .resetn(resetn), .por_n(por_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .fl_req(fl_req), .fl_rsp(fl_rsp), .irq(irq));

  fetch_requester fetch_requester_i (
    .mclk(mclk), .resetn(resetn), .go(go), .fetch(fetch), .dbg(dbg),
    .addr(faddr), .fl_req(fl_req), .fl_rsp(fl_rsp), .got(got));

  always begin
    #5;
    mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // protection only tightens; codes above fetch-only are ignored
  function automatic logic [7:0] prot_next(logic [7:0] o, logic [7:0] r);
    for (int i = 0; i < 4; i++) begin
      if (r[2*i+:2] >= o[2*i+:2] && r[2*i+:2] <= 2'h2)
        o[2*i+:2] = r[2*i+:2];
    end
    return o;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // request held until the rising edge that sees waitrequest low
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge mclk);
    end
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rchk(input string nm, input logic [5:0] a,
                      input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(nm, e, r);
  endtask

  task automatic op(input logic [12:0] a, input logic [31:0] d,
                    input logic [3:0] c);
    logic [31:0] r;
    int n;
    wr(`FP_OFS_ADDR, {19'h0, a});
    wr(`FP_OFS_DATA, d);
    wr(`FP_OFS_CMD, {28'h0, c});
    r = 32'h1;
    for (n = 0; n < 500 && r[`FP_CMD_BUSY] !== 1'b0; n++)
      bus(1'b0, `FP_OFS_CMD, 32'h0, r);
    chk("busy", 32'h0, {31'h0, r[`FP_CMD_BUSY]});
  endtask

  task automatic pchk(input logic f, input logic dg, input logic [12:0] a,
                      input logic den, input logic [31:0] e);
    int n;
    n = 0;
    @(posedge mclk);
    go    <= 1'b1;
    fetch <= f;
    dbg   <= dg;
    faddr <= a;
    @(posedge mclk);
    go <= 1'b0;
    @(negedge mclk);
    while (got.valid !== 1'b1 && n < 8) begin
      n++;
      @(negedge mclk);
    end
    chk("valid", 32'h1, {31'h0, got.valid});
    chk("denied", {31'h0, den}, {31'h0, got.denied});
    chk("word", e, got.data);
  endtask

  task automatic rst(input logic por);
    @(posedge mclk);
    resetn <= 1'b0;
    if (por) por_n <= 1'b0;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    por_n  <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #300000;
    errors++;
    $display("Error watchdog expected done seen hang");
    end_of_test();
  end

  initial begin
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    por_n  <= 1'b1;
    rchk("mask", `FP_OFS_MASK, 32'h0);
    rchk("stat", `FP_OFS_STAT, 32'h0);
    rchk("prot", `FP_OFS_PROT, {24'h0, `FP_NV_PROT_RST});
    rchk("user0", `FP_OFS_USER0, `FP_NV_USER_RST);
    rchk("unmapped", 6'h3c, 32'h0);
    $display("reset values done");
    wr(`FP_OFS_MASK, 32'h1);
    op(13'h000, 32'h0, 4'h2);
    chk("irq", 32'h1, {31'h0, irq});
    rchk("mstat", `FP_OFS_MSTAT, 32'h1);
    wr(`FP_OFS_STAT, 32'h7);
    // irq follows the clearing edge; look once it has settled
    @(negedge mclk);
    chk("irq", 32'h0, {31'h0, irq});
    wr(`FP_OFS_MASK, 32'h0);
    op(13'h800, 32'h0, 4'h2);
    rchk("stat", `FP_OFS_STAT, 32'h1);
    rchk("mstat", `FP_OFS_MSTAT, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    pchk(1'b0, 1'b0, 13'h3fc, 1'b0, 32'hffffffff);
    pchk(1'b1, 1'b0, 13'hbfc, 1'b0, 32'hffffffff);
    $display("erase done");
    // each word is programmed once only since its page was erased
    for (int i = 0; i < 4; i++) begin
      w0 = rnd();
      op({9'h0, i[1:0], 2'h0}, w0, 4'h1);
      pchk(1'b0, i[0], {9'h0, i[1:0], 2'h0}, 1'b0, w0);
    end
    wr(`FP_OFS_STAT, 32'h7);
    op(13'h0012, 32'h0, 4'h1);
    rchk("perr", `FP_OFS_STAT, 32'h4);
    pchk(1'b0, 1'b0, 13'h0010, 1'b0, 32'hffffffff);
    wr(`FP_OFS_STAT, 32'h7);
    op(13'h0404, 32'h0, 4'h2);
    rchk("perr", `FP_OFS_STAT, 32'h4);
    w1 = rnd();
    op(13'h800, w1, 4'h1);
    $display("program done");
    pe = prot_next(8'h00, 8'h04);
    wr(`FP_OFS_PROT, 32'h04);
    rchk("prot", `FP_OFS_PROT, {24'h0, pe});
    wr(`FP_OFS_STAT, 32'h7);
    op(13'h800, 32'h0, 4'h2);
    bus(1'b0, `FP_OFS_STAT, 32'h0, q);
    chk("acc", 32'h1, {31'h0, q[`FP_ST_ACC]});
    op(13'h804, 32'h0, 4'h1);
    pchk(1'b0, 1'b0, 13'h800, 1'b0, w1);
    pchk(1'b0, 1'b0, 13'h804, 1'b0, 32'hffffffff);
    pchk(1'b1, 1'b0, 13'h800, 1'b0, w1);
    for (int v = 0; v < 4; v++) begin
      pe = prot_next(pe, {4'h0, v[1:0], 2'h3});
      wr(`FP_OFS_PROT, {28'h0, v[1:0], 2'h3});
      rchk("prot", `FP_OFS_PROT, {24'h0, pe});
    end
    wr(`FP_OFS_STAT, 32'h7);
    pchk(1'b0, 1'b0, 13'h800, 1'b1, 32'h0);
    pchk(1'b0, 1'b1, 13'h800, 1'b1, 32'h0);
    pchk(1'b1, 1'b1, 13'h800, 1'b0, w1);
    bus(1'b0, `FP_OFS_STAT, 32'h0, q);
    chk("acc", 32'h1, {31'h0, q[`FP_ST_ACC]});
    $display("protection done");
    rst(1'b0);
    rchk("prot", `FP_OFS_PROT, {24'h0, `FP_NV_PROT_RST});
    pchk(1'b0, 1'b0, 13'h800, 1'b0, w1);
    wr(`FP_OFS_PROT, 32'h01);
    op(13'h0, 32'h0, 4'h4);
    rst(1'b0);
    rchk("prot", `FP_OFS_PROT, 32'h01);
    w0 = rnd();
    w1 = rnd();
    wr(`FP_OFS_USER0, w0);
    wr(`FP_OFS_USER1, w1);
    rchk("user0", `FP_OFS_USER0, w0);
    rchk("user1", `FP_OFS_USER1, w1);
    rst(1'b0);
    rchk("user0", `FP_OFS_USER0, `FP_NV_USER_RST);
    wr(`FP_OFS_USER0, w0);
    wr(`FP_OFS_USER1, w1);
    op(13'h0, 32'h0, 4'h8);
    rst(1'b0);
    rchk("user0", `FP_OFS_USER0, w0);
    rchk("user1", `FP_OFS_USER1, w1);
    rst(1'b1);
    rchk("user1", `FP_OFS_USER1, `FP_NV_USER_RST);
    rchk("prot", `FP_OFS_PROT, {24'h0, `FP_NV_PROT_RST});
    $display("commit done");
    end_of_test();
  end
endmodule
